// >>> tb_top.sv
// self-checking bench for the otg event-flag block
`timescale 1ns/1ps
module tb_top import uoe_pkg::*;;
  localparam int MS = 16;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [2:0]  ev = 3'h0;
  logic [31:0] rd_data, wd;
  logic        irq, cable_id, line_se0, line_jstate, wake_activity, session_valid, session_end, a_vbus_valid;
  logic [7:0]  mf, me;
  logic [2:0]  ec [4] = '{3'h3, 3'h2, 3'h1, 3'h4};
  logic [7:0]  ef [4] = '{8'h05, 8'h0D, 8'h80, 8'h10};
  int          seed = 29791;
  int          num_errors = 0;
  int          n_compared = 0;

  always #4 clock = ~clock;
  uoe_event_flags #(.MS_CYCLES(MS)) u_uoe_event_flags (.clock, .resetn, .addr, .wr_data, .wr_en, .rd_en,
    .rd_data, .cable_id, .line_se0, .line_jstate, .wake_activity, .session_valid, .session_end,
    .a_vbus_valid, .irq);
  uoe_usb_side_model u_uoe_usb_side_model (.clock, .ev, .cable_id, .line_se0, .line_jstate,
    .wake_activity, .session_valid, .session_end, .a_vbus_valid);

  // masked compare of a read word
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_compared++;
    if ((got & ~m) !== (exp & ~m))
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // request level against the model
  task automatic cmp_irq;
    #1;
    n_compared++;
    if (irq !== |(mf & me))
    begin
      num_errors++;
      $display("unexpected at %0t: irq %b", $time, irq);
    end
    @(posedge clock);
  endtask
  // bus read, data checked in its one valid cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 cmp(rd_data, e, m);
    @(posedge clock);
  endtask
  // bus write, model follows
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
    if (a == UOE_OFF_FLAGS)
      mf = mf & ~d[7:0];
    if (a == UOE_OFF_ENABLES)
      me = d[7:0] & 8'hFD;
  endtask
  // one far-side command; flag is readable right after
  task automatic evt(input logic [2:0] c, input logic [7:0] f);
    ev <= c;
    @(posedge clock);
    ev <= 3'h0;
    @(posedge clock);
    mf = mf | f;
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    mf = 8'h00;
    me = 8'h00;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(UOE_OFF_FLAGS, 32'h0, 32'h40);
    rd(UOE_OFF_ENABLES, 32'h0, 32'h0);
    wr(UOE_OFF_STATUS, 32'hFF);
    wr(8'h0C, 32'hFF);
    rd(UOE_OFF_STATUS, 32'h84, 32'h20);
    rd(8'h0C, 32'h0, 32'h0);
    repeat (4)
    begin
      wd = $random(seed) & 32'hFFFFFFBF;
      wr(UOE_OFF_ENABLES, wd);
      rd(UOE_OFF_ENABLES, wd & 32'hFD, 32'h0);
      cmp_irq;
    end
    $display("registers test done");
    wr(UOE_OFF_ENABLES, 32'hBD);
    for (int i = 0; i < 4; i++)
    begin
      evt(ec[i], ef[i]);
      rd(UOE_OFF_FLAGS, {24'h0, mf}, 32'h60);
      cmp_irq;
      wr(UOE_OFF_FLAGS, {24'h0, mf});
      cmp_irq;
    end
    ev <= 3'h4;
    @(posedge clock);
    ev <= 3'h0;
    wr(UOE_OFF_FLAGS, 32'h10);
    mf[4] = 1'b1;
    rd(UOE_OFF_FLAGS, {24'h0, mf}, 32'h60);
    wr(UOE_OFF_FLAGS, 32'hFFFFFFFF);
    $display("events test done");
    evt(3'h5, 8'h00);
    rd(UOE_OFF_FLAGS, {24'h0, mf}, 32'h40);
    rd(UOE_OFF_STATUS, {24'h0, cable_id, 3'h0, session_valid, session_end, 1'b0, a_vbus_valid}, 32'h0);
    mf[5] = 1'b1;
    repeat (3 * MS) @(posedge clock);
    rd(UOE_OFF_FLAGS, {24'h0, mf}, 32'h40);
    rd(UOE_OFF_STATUS, {24'h0, cable_id, 3'h2, session_valid, session_end, 1'b0, a_vbus_valid}, 32'h0);
    cmp_irq;
    wr(UOE_OFF_FLAGS, 32'hFF);
    repeat (3 * MS) @(posedge clock);
    rd(UOE_OFF_FLAGS, 32'h0, 32'h40);
    wr(UOE_OFF_ENABLES, 32'h40);
    repeat (2 * MS) @(posedge clock);
    rd(UOE_OFF_FLAGS, 32'h40, 32'hFFFFFFBF);
    mf[6] = 1'b1;
    cmp_irq;
    wr(UOE_OFF_ENABLES, 32'h0);
    cmp_irq;
    $display("timers test done");
    resetn <= 1'b0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    mf = 8'h00;
    rd(UOE_OFF_FLAGS, 32'h0, 32'h40);
    rd(UOE_OFF_ENABLES, 32'h0, 32'h0);
    cmp_irq;
    $display("reset test done");
    end_sim;
  end

  // watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge clock);
    num_errors++;
    end_sim;
  end
endmodule

bind uoe_event_flags uoe_event_flags_properties u_props (.clock, .resetn, .addr, .wr_en, .rd_en, .rd_data,
  .cable_id, .wake_activity, .session_valid, .session_end, .a_vbus_valid, .irq);

// >>> uoe_change_det.sv
// change and rise detector for a sampled level
`timescale 1ns/1ps

module uoe_change_det
  import uoe_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // sampled level
  input  wire logic [WIDTH-1:0] sig,
  // detections, valid in the cycle the level moves
  output logic                  chg,
  output logic                  rise
);

  typedef struct packed
  {
    logic             primed;
    logic [WIDTH-1:0] prev;
  } uoe_det_s;

  uoe_det_s st_ff;
  uoe_det_s nxt_st;

  // first sample after reset only primes the history
  always_comb
  begin
    nxt_st        = st_ff;
    nxt_st.primed = 1'b1;
    nxt_st.prev   = sig;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // compare against last sample
  assign chg  = st_ff.primed && (sig != st_ff.prev);
  assign rise = st_ff.primed && (|(sig & ~st_ff.prev));

endmodule

// >>> uoe_event_flags.sv
// otg event flags, enables, live status and interrupt request
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module uoe_event_flags
  import uoe_pkg::*;
#(
  parameter int MS_CYCLES = UOE_MS_CYCLES
)
(
  // usb clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // register port
  input  wire logic [UOE_ADDR_W-1:0] addr,
  input  wire logic [UOE_DATA_W-1:0] wr_data,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic      [UOE_DATA_W-1:0] rd_data,
  // cable and line state
  input  wire logic                  cable_id,
  input  wire logic                  line_se0,
  input  wire logic                  line_jstate,
  // wake-up activity detector pulse
  input  wire logic                  wake_activity,
  // vbus comparators
  input  wire logic                  session_valid,
  input  wire logic                  session_end,
  input  wire logic                  a_vbus_valid,
  // interrupt request
  output logic                       irq
);

  // register state kept in this module; detectors and timers keep their own
  typedef struct packed
  {
    logic [UOE_REG_W-1:0]  flags;
    logic [UOE_REG_W-1:0]  enables;
    logic [1:0]            reported_line;
    logic [UOE_DATA_W-1:0] rd_data;
    logic                  irq;
  } uoe_top_s;

  uoe_top_s st_ff;
  uoe_top_s nxt_st;

  // event detections
  logic                 cable_chg;
  logic                 line_chg;
  logic                 line_stable;
  logic                 send_chg;
  logic                 send_rise;
  logic                 adev_chg;
  logic                 ms_tick;
  logic [1:0]           line_now;

  // per-cycle set and clear vectors
  logic [UOE_REG_W-1:0] set_vec;
  logic [UOE_REG_W-1:0] clr_vec;
  logic [UOE_REG_W-1:0] live_status;

  // register port decode
  logic                 wr_flags;
  logic                 wr_enables;
  logic                 rd_flags;
  logic                 rd_enables;
  logic                 rd_status;
  logic [UOE_REG_W-1:0] wr_byte;

  // line qualified against a move in this very cycle
  logic                 line_settled;
  logic                 line_new;

  // next register values and the register picked for reading
  logic [UOE_REG_W-1:0] nxt_flags;
  logic [UOE_REG_W-1:0] nxt_enables;
  logic [UOE_REG_W-1:0] pending;
  logic [UOE_REG_W-1:0] rd_view;

  assign line_now = {line_se0, line_jstate};

  // cable identification change
  uoe_change_det #(
    .WIDTH (1)
  ) u_cable_det (
    .clock  (clock),
    .resetn (resetn),
    .sig    (cable_id),
    .chg    (cable_chg),
    .rise   ()
  );

  // line state change, restarts the stability interval
  uoe_change_det #(
    .WIDTH (2)
  ) u_line_det (
    .clock  (clock),
    .resetn (resetn),
    .sig    (line_now),
    .chg    (line_chg),
    .rise   ()
  );

  // session-end comparator: change and fall below session end
  uoe_change_det #(
    .WIDTH (1)
  ) u_send_det (
    .clock  (clock),
    .resetn (resetn),
    .sig    (session_end),
    .chg    (send_chg),
    .rise   (send_rise)
  );

  // a-device vbus-valid comparator change
  uoe_change_det #(
    .WIDTH (1)
  ) u_adev_det (
    .clock  (clock),
    .resetn (resetn),
    .sig    (a_vbus_valid),
    .chg    (adev_chg),
    .rise   ()
  );

  // free-running one-millisecond timer on the usb clock
  uoe_ms_counter #(
    .LIMIT (MS_CYCLES),
    .WRAP  (1'b1)
  ) u_ms_timer (
    .clock   (clock),
    .resetn  (resetn),
    .restart (1'b0),
    .done    (ms_tick)
  );

  // line held unchanged for one millisecond
  uoe_ms_counter #(
    .LIMIT (MS_CYCLES),
    .WRAP  (1'b0)
  ) u_line_timer (
    .clock   (clock),
    .resetn  (resetn),
    .restart (line_chg),
    .done    (line_stable)
  );

  // a line that moved in this cycle is not settled yet
  assign line_settled = line_stable && !line_chg;
  assign line_new     = line_settled && (line_now != st_ff.reported_line);

  // live comparator and line conditions, unused bits zero
  always_comb
  begin
    live_status               = '0;
    live_status[UOE_ST_CABLE] = cable_id;
    live_status[UOE_ST_LINE]  = line_settled;
    live_status[UOE_ST_SESS]  = session_valid;
    live_status[UOE_ST_SEND]  = session_end;
    live_status[UOE_ST_ADEV]  = a_vbus_valid;
  end

  // register port decode, only the low byte of write data matters
  assign wr_byte    = wr_data[UOE_REG_W-1:0];
  assign wr_flags   = wr_en && (addr == UOE_OFF_FLAGS);
  assign wr_enables = wr_en && (addr == UOE_OFF_ENABLES);
  assign rd_flags   = rd_en && (addr == UOE_OFF_FLAGS);
  assign rd_enables = rd_en && (addr == UOE_OFF_ENABLES);
  assign rd_status  = rd_en && (addr == UOE_OFF_STATUS);

  // hardware event sources, one per implemented flag
  always_comb
  begin
    set_vec                = '0;
    set_vec[UOE_BIT_CABLE] = cable_chg;
    set_vec[UOE_BIT_TIMER] = ms_tick;
    set_vec[UOE_BIT_LINE]  = line_new;
    set_vec[UOE_BIT_WAKE]  = wake_activity;
    set_vec[UOE_BIT_SESS]  = send_rise;
    set_vec[UOE_BIT_BDEV]  = send_chg;
    set_vec[UOE_BIT_ADEV]  = adev_chg;
  end

  // write one to clear, only on implemented bits
  always_comb
  begin
    clr_vec = '0;
    if (wr_flags)
      clr_vec = wr_byte & UOE_IMPL_MASK;
  end

  // one sticky cell per implemented bit position of flags and enables
  for (genvar b = 0; b < UOE_REG_W; b++)
  begin : g_bit
    if (UOE_IMPL_MASK[b])
    begin : g_impl
      // a new event outweighs a same-cycle clear
      assign nxt_flags[b]   = set_vec[b] || (st_ff.flags[b] && !clr_vec[b]);
      // enable keeps its value until written
      assign nxt_enables[b] = wr_enables ? wr_byte[b] : st_ff.enables[b];
      // flag and enable pair that stands after this edge
      assign pending[b]     = nxt_flags[b] && nxt_enables[b];
    end
    else
    begin : g_none
      // unimplemented position stays zero
      assign nxt_flags[b]   = 1'b0;
      assign nxt_enables[b] = 1'b0;
      assign pending[b]     = 1'b0;
    end
  end

  // register picked by the read strobe, nothing picked reads zero
  always_comb
  begin
    rd_view = '0;
    if (rd_flags)
      rd_view = st_ff.flags;
    else if (rd_enables)
      rd_view = st_ff.enables;
    else if (rd_status)
      rd_view = live_status;
  end

  // next state: flags, enables, reported line, read data, request
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.flags   = nxt_flags;
    nxt_st.enables = nxt_enables;
    // remember the stable line value just reported
    if (line_new)
      nxt_st.reported_line = line_now;
    // read data stand only in the cycle after the read strobe
    nxt_st.rd_data = UOE_DATA_W'(rd_view);
    // request follows the registered flag and enable pairs
    nxt_st.irq = |pending;
  end

  // state register, cleared at reset
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      st_ff.flags         <= UOE_RESET_FLAGS;
      st_ff.enables       <= UOE_RESET_ENABLES;
      st_ff.reported_line <= UOE_RESET_LINE;
      st_ff.rd_data       <= UOE_RESET_RDATA;
      st_ff.irq           <= 1'b0;
    end
    else
    begin
      st_ff.flags         <= nxt_st.flags;
      st_ff.enables       <= nxt_st.enables;
      st_ff.reported_line <= nxt_st.reported_line;
      st_ff.rd_data       <= nxt_st.rd_data;
      st_ff.irq           <= nxt_st.irq;
    end
  end

  // outputs straight from flip-flops
  assign rd_data = st_ff.rd_data;
  assign irq     = st_ff.irq;

endmodule

// >>> uoe_event_flags_properties.sv
// port assertions for the otg event-flag block
`timescale 1ns/1ps
module uoe_event_flags_properties
  import uoe_pkg::*;
(
  // clock, reset, register port
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [7:0]  addr,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data,
  // levels and request
  input wire logic        cable_id,
  input wire logic        wake_activity,
  input wire logic        session_valid,
  input wire logic        session_end,
  input wire logic        a_vbus_valid,
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // flag read in the cycle after an event edge
  wire fl_rd = rd_en && addr == UOE_OFF_FLAGS;

  chk_rst_quiet: assert property ($rose(resetn) |-> !irq && rd_data == 32'h0)
    else $error("busy after reset");
  chk_rd_idle: assert property (!rd_en |=> rd_data == 32'h0)
    else $error("stray read data");
  chk_loose_zero: assert property (rd_en |=> (rd_data & 32'hFFFFFF02) == 32'h0)
    else $error("loose bit set");
  chk_cable_flag: assert property ($past(resetn, 2) && $changed(cable_id) ##1 fl_rd |=> rd_data[7])
    else $error("cable change lost");
  chk_wake_flag: assert property (wake_activity ##1 fl_rd |=> rd_data[4])
    else $error("wake lost");
  chk_sess_drop: assert property ($past(resetn, 2) && $rose(session_end) ##1 fl_rd |=> rd_data[3])
    else $error("session drop lost");
  chk_bdev_flag: assert property ($past(resetn, 2) && $changed(session_end) ##1 fl_rd |=> rd_data[2])
    else $error("session end change lost");
  chk_adev_flag: assert property ($past(resetn, 2) && $changed(a_vbus_valid) ##1 fl_rd |=> rd_data[0])
    else $error("vbus change lost");
  chk_live_status: assert property (rd_en && addr == UOE_OFF_STATUS |=> rd_data[7] == $past(cable_id)
    && rd_data[3] == $past(session_valid) && rd_data[2] == $past(session_end)
    && rd_data[0] == $past(a_vbus_valid)) else $error("status mismatch");
  chk_irq_hold: assert property (irq && !wr_en |=> irq)
    else $error("request dropped");
endmodule

// >>> uoe_ms_counter.sv
// millisecond interval counter, free-running or restartable
`timescale 1ns/1ps

module uoe_ms_counter
  import uoe_pkg::*;
#(
  parameter int LIMIT = UOE_MS_CYCLES,
  parameter bit WRAP  = 1'b1
)
(
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // restart the interval
  input  wire logic restart,
  // wrap: one-cycle expiry pulse; hold: level while interval reached
  output logic      done
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  typedef struct packed
  {
    logic [CW-1:0] count;
    logic          done;
  } uoe_cnt_s;

  uoe_cnt_s st_ff;
  uoe_cnt_s nxt_st;

  // count, then wrap or saturate at the last cycle
  always_comb
  begin
    nxt_st = st_ff;
    if (restart)
      nxt_st.count = '0;
    else if (st_ff.count == LAST)
      nxt_st.count = WRAP ? '0 : LAST;
    else
      nxt_st.count = CW'(st_ff.count + 1'b1);
    if (WRAP)
      nxt_st.done = !restart && (st_ff.count == LAST);
    else
      nxt_st.done = !restart && (nxt_st.count == LAST);
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign done = st_ff.done;

endmodule

// >>> uoe_pkg.sv
// shared constants for the otg event-flag block
package uoe_pkg;

  // register port widths
  localparam int UOE_ADDR_W = 8;
  localparam int UOE_DATA_W = 32;
  localparam int UOE_REG_W  = 8;

  // register byte offsets
  localparam logic [7:0] UOE_OFF_FLAGS   = 8'h00;
  localparam logic [7:0] UOE_OFF_ENABLES = 8'h04;
  localparam logic [7:0] UOE_OFF_STATUS  = 8'h08;

  // event flag and enable bit positions
  localparam int UOE_BIT_CABLE = 7;
  localparam int UOE_BIT_TIMER = 6;
  localparam int UOE_BIT_LINE  = 5;
  localparam int UOE_BIT_WAKE  = 4;
  localparam int UOE_BIT_SESS  = 3;
  localparam int UOE_BIT_BDEV  = 2;
  localparam int UOE_BIT_ADEV  = 0;

  // live status bit positions
  localparam int UOE_ST_CABLE = 7;
  localparam int UOE_ST_LINE  = 5;
  localparam int UOE_ST_SESS  = 3;
  localparam int UOE_ST_SEND  = 2;
  localparam int UOE_ST_ADEV  = 0;

  // implemented bits of flag and enable registers
  localparam logic [7:0] UOE_IMPL_MASK = 8'hFD;

  // values after reset
  localparam logic [7:0]  UOE_RESET_FLAGS   = 8'h00;
  localparam logic [7:0]  UOE_RESET_ENABLES = 8'h00;
  localparam logic [1:0]  UOE_RESET_LINE    = 2'h0;
  localparam logic [31:0] UOE_RESET_RDATA   = 32'h0000_0000;

  // timing: usb clock rate and the one-millisecond interval
  localparam int UOE_CLK_FREQ_KHZ = 48000;
  localparam int UOE_TICK_TIME_MS = 1;
  localparam int UOE_MS_CYCLES    = UOE_CLK_FREQ_KHZ * UOE_TICK_TIME_MS;

endpackage

// >>> uoe_usb_side_model.sv
// cable, comparator and line stand-in
`timescale 1ns/1ps
module uoe_usb_side_model
(
  // clock and bench command
  input  wire logic       clock,
  input  wire logic [2:0] ev,
  // levels seen by the block
  output logic            cable_id,
  output logic            line_se0,
  output logic            line_jstate,
  output logic            wake_activity,
  output logic            session_valid,
  output logic            session_end,
  output logic            a_vbus_valid
);
  // no cable, no vbus, idle line
  initial {cable_id, line_se0, line_jstate, wake_activity, session_valid, session_end, a_vbus_valid} = 7'h42;
  // levels move just after the edge taking a command
  always @(posedge clock)
  begin
    wake_activity <= (ev == 3'h4);
    case (ev)
      3'h1: cable_id <= ~cable_id;
      3'h2: {session_valid, session_end, a_vbus_valid} <= 3'h2;
      3'h3: {session_valid, session_end, a_vbus_valid} <= 3'h5;
      3'h5: {line_se0, line_jstate} <= 2'h1;
      default: ;
    endcase
  end
endmodule
